// *** logic/eeb_pkg.sv ***
// constants, field layout and state codes of the two-wire memory slave
// assumes a 125 MHz system clock and the 4 Kbit organisation (one page bit in the select byte)
package eeb_pkg;

    localparam int CLK_PERIOD_NS = 8;
    localparam int PROG_TIME_NS = 5000000;
    localparam int PROG_CYCLES_DFLT = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // arbitrary value
    localparam logic [3:0] TYPE_ID_DFLT = 4'hC;

    localparam int HI_BITS = 1;
    localparam int MEM_AW = 8 + HI_BITS;
    localparam int MEM_DEPTH = 1 << MEM_AW;
    localparam int PAGE_BITS = 4;
    localparam int PAGE_LEN = 1 << PAGE_BITS;
    localparam int PIN_W = 6;

    localparam int SEL_TYPE_LSB = 4;
    localparam int SEL_CHIP_LSB = 1;
    localparam int SEL_RW_BIT = 0;
    localparam int CHIP_W = 3;

    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
    localparam logic [3:0] CNT_LAST_BIT = 4'h7;
    localparam logic [3:0] CNT_BYTE = 4'h8;
    localparam logic [3:0] CNT_ACK = 4'h9;

    localparam logic [7:0] MEM_INIT = 8'hFF;

    typedef enum logic [4:0] {
        PH_IDLE = 5'h01,
        PH_SEL = 5'h02,
        PH_ADDR = 5'h04,
        PH_WDATA = 5'h08,
        PH_RDATA = 5'h10
    } eeb_state_e;

endpackage

// *** logic/eeb_ev_if.sv ***
// bus events and synchronised pin levels passed from the pin front end to the protocol engine
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`default_nettype none
interface eeb_ev_if;
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda_lvl;
    logic wi_lvl;
    logic [eeb_pkg::CHIP_W-1:0] strap;

    modport src (output start, output stop, output scl_rise, output scl_fall,
                 output sda_lvl, output wi_lvl, output strap);
    modport dst (input start, input stop, input scl_rise, input scl_fall,
                 input sda_lvl, input wi_lvl, input strap);
endinterface
`default_nettype wire

// *** logic/eeb_pin_sync.sv ***
// pin front end: two-stage synchronisers, scl edge and start/stop detection
// assumes all pins are asynchronous to clk and the bus clock is far slower than clk
`timescale 1ns/1ps
`default_nettype none
module eeb_pin_sync (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic write_inhibit,
    input wire logic [eeb_pkg::CHIP_W-1:0] strap_in,
    eeb_ev_if.src ev
);
    logic [eeb_pkg::PIN_W-1:0] meta_q;
    logic [eeb_pkg::PIN_W-1:0] sync_q;
    logic scl_hist_q;
    logic sda_hist_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            // bus idles high; a low reset value would fake scl/sda edges after release
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= {strap_in, write_inhibit, sda_in, scl_in};
            sync_q <= meta_q;
        end
    end

    // history stage reads only the second flop
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_hist_q <= 1'b1;
            sda_hist_q <= 1'b1;
        end else begin
            scl_hist_q <= sync_q[0];
            sda_hist_q <= sync_q[1];
        end
    end

    assign ev.start = sync_q[0] && scl_hist_q && sda_hist_q && !sync_q[1];
    assign ev.stop = sync_q[0] && scl_hist_q && !sda_hist_q && sync_q[1];
    assign ev.scl_rise = sync_q[0] && !scl_hist_q;
    assign ev.scl_fall = !sync_q[0] && scl_hist_q;
    assign ev.sda_lvl = sync_q[1];
    assign ev.wi_lvl = sync_q[2];
    assign ev.strap = sync_q[5:3];
endmodule // eeb_pin_sync
`default_nettype wire

// *** logic/eeb_slave.sv ***
// two-wire serial memory slave: select decode, byte/page write, self-timed program, reads
// assumes scl/sda/straps/write_inhibit come straight from pins; sda is open drain
`timescale 1ns/1ps
`default_nettype none
module eeb_slave #(
    parameter int unsigned PROG_CYCLES = eeb_pkg::PROG_CYCLES_DFLT,
    parameter logic [3:0] TYPE_ID = eeb_pkg::TYPE_ID_DFLT
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic write_inhibit,
    input wire logic strap0,
    input wire logic strap1,
    input wire logic strap2,
    output logic busy
);
    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    eeb_ev_if ev ();

    eeb_pkg::eeb_state_e ph_q;
    logic [3:0] cnt_q;
    logic [7:0] sr_q;
    logic [7:0] rd_sr_q;
    logic rw_q;
    logic nack_q;
    logic oe_q;
    logic wi_seen_q;
    logic ten_q;
    logic busy_q;
    logic [31:0] prog_cnt_q;
    logic [eeb_pkg::MEM_AW-1:0] addr_q;
    logic [7:0] page_buf_q [eeb_pkg::PAGE_LEN];
    logic [eeb_pkg::PAGE_LEN-1:0] pend_q;
    logic [7:0] mem_q [eeb_pkg::MEM_DEPTH];

    logic ev_start;
    logic ev_stop;
    logic ev_rise;
    logic ev_fall;
    logic byte_end;
    logic ack_end;
    logic sel_ok;
    logic prog_go;
    logic prog_done;
    logic [7:0] mem_rd;
    logic [eeb_pkg::PAGE_BITS-1:0] page_idx;

    // type and the strapped chip bits above the page bit (strap1, strap2) must agree; strap0 is not compared
    function automatic logic sel_match(input logic [7:0] sel, input logic [eeb_pkg::CHIP_W-1:0] strap,
                                       input logic [3:0] tid);
        logic ok;
        ok = (sel[7:eeb_pkg::SEL_TYPE_LSB] == tid);
        for (int i = eeb_pkg::HI_BITS; i < eeb_pkg::CHIP_W; i++) begin
            if (sel[eeb_pkg::SEL_CHIP_LSB + i] != strap[i]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // pin front end

    eeb_pin_sync u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .write_inhibit(write_inhibit),
        .strap_in({strap2, strap1, strap0}),
        .ev(ev.src)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // decodes

    assign ev_start = ev.start && !busy_q;
    assign ev_stop = ev.stop && !busy_q;
    assign ev_rise = ev.scl_rise && !busy_q && (ph_q != eeb_pkg::PH_IDLE);
    assign ev_fall = ev.scl_fall && !busy_q && (ph_q != eeb_pkg::PH_IDLE);
    assign byte_end = ev_fall && (cnt_q == eeb_pkg::CNT_BYTE);
    assign ack_end = ev_fall && (cnt_q == eeb_pkg::CNT_ACK);
    assign sel_ok = sel_match(sr_q, ev.strap, TYPE_ID);
    assign mem_rd = mem_q[addr_q];
    assign page_idx = addr_q[eeb_pkg::PAGE_BITS-1:0];
    assign prog_go = ev_stop && ten_q && (ph_q == eeb_pkg::PH_WDATA)
                     && (cnt_q <= eeb_pkg::CNT_ONE) && (|pend_q);
    assign prog_done = busy_q && (prog_cnt_q == 32'(PROG_CYCLES - 1));

    assign sda_out = 1'b0;
    assign sda_oe = oe_q;
    assign busy = busy_q;

    ////////////////////////////////////////////////////////////////////////////////
    // protocol state and bit counter

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ph_q <= eeb_pkg::PH_IDLE;
            cnt_q <= eeb_pkg::CNT_ZERO;
        end else if (busy_q) begin
            ph_q <= eeb_pkg::PH_IDLE;
            cnt_q <= eeb_pkg::CNT_ZERO;
        end else if (ev_start) begin
            ph_q <= eeb_pkg::PH_SEL;
            cnt_q <= eeb_pkg::CNT_ZERO;
        end else if (ev_stop) begin
            ph_q <= eeb_pkg::PH_IDLE;
            cnt_q <= eeb_pkg::CNT_ZERO;
        end else if (ev_rise) begin
            if (cnt_q != eeb_pkg::CNT_ACK) begin
                cnt_q <= cnt_q + eeb_pkg::CNT_ONE;
            end
        end else if (byte_end) begin
            if (ph_q == eeb_pkg::PH_SEL && !sel_ok) begin
                ph_q <= eeb_pkg::PH_IDLE;
                cnt_q <= eeb_pkg::CNT_ZERO;
            end
        end else if (ack_end) begin
            cnt_q <= eeb_pkg::CNT_ZERO;
            unique case (ph_q)
                eeb_pkg::PH_SEL: begin
                    ph_q <= rw_q ? eeb_pkg::PH_RDATA : eeb_pkg::PH_ADDR;
                end
                eeb_pkg::PH_ADDR: begin
                    ph_q <= eeb_pkg::PH_WDATA;
                end
                eeb_pkg::PH_WDATA: begin
                    ph_q <= eeb_pkg::PH_WDATA;
                end
                eeb_pkg::PH_RDATA: begin
                    if (nack_q) begin
                        ph_q <= eeb_pkg::PH_IDLE;
                    end
                end
                eeb_pkg::PH_IDLE: begin
                    ph_q <= eeb_pkg::PH_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // receive shift, direction bit and master acknowledge sample

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sr_q <= '0;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
        end else begin
            if (ev_rise && cnt_q < eeb_pkg::CNT_BYTE) begin
                sr_q <= {sr_q[6:0], ev.sda_lvl};
            end
            if (ev_rise && cnt_q == eeb_pkg::CNT_BYTE) begin
                nack_q <= ev.sda_lvl;
            end
            if (byte_end && ph_q == eeb_pkg::PH_SEL) begin
                rw_q <= sr_q[eeb_pkg::SEL_RW_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sda drive: acks while receiving, data bits while transmitting

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            oe_q <= 1'b0;
        end else if (busy_q || ev_start || ev_stop) begin
            oe_q <= 1'b0;
        end else if (byte_end) begin
            unique case (ph_q)
                eeb_pkg::PH_SEL: oe_q <= sel_ok;
                eeb_pkg::PH_ADDR: oe_q <= 1'b1;
                eeb_pkg::PH_WDATA: oe_q <= !wi_seen_q;
                eeb_pkg::PH_RDATA: oe_q <= 1'b0;
                eeb_pkg::PH_IDLE: oe_q <= 1'b0;
            endcase
        end else if (ack_end) begin
            if ((ph_q == eeb_pkg::PH_SEL && rw_q) || (ph_q == eeb_pkg::PH_RDATA && !nack_q)) begin
                oe_q <= !mem_rd[7];
            end else begin
                oe_q <= 1'b0;
            end
        end else if (ev_fall) begin
            if (ph_q == eeb_pkg::PH_RDATA && cnt_q <= eeb_pkg::CNT_LAST_BIT) begin
                oe_q <= !rd_sr_q[7];
            end else begin
                oe_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_sr_q <= '0;
        end else if (ack_end) begin
            rd_sr_q <= {mem_rd[6:0], 1'b0};
        end else if (ev_fall && ph_q == eeb_pkg::PH_RDATA) begin
            rd_sr_q <= {rd_sr_q[6:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // address counter

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            addr_q <= '0;
        end else if (byte_end) begin
            if (ph_q == eeb_pkg::PH_SEL && sel_ok) begin
                addr_q[eeb_pkg::MEM_AW-1:8] <= sr_q[eeb_pkg::SEL_CHIP_LSB +: eeb_pkg::HI_BITS];
            end else if (ph_q == eeb_pkg::PH_ADDR) begin
                addr_q[7:0] <= sr_q;
            end else if (ph_q == eeb_pkg::PH_WDATA && !wi_seen_q) begin
                addr_q[eeb_pkg::PAGE_BITS-1:0] <= page_idx + 1'b1;
            end else if (ph_q == eeb_pkg::PH_RDATA) begin
                addr_q <= addr_q + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write protect window and tenth bit slot

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wi_seen_q <= 1'b0;
        end else if (ev_start) begin
            wi_seen_q <= ev.wi_lvl;
        end else if (ph_q == eeb_pkg::PH_SEL || ph_q == eeb_pkg::PH_ADDR) begin
            wi_seen_q <= wi_seen_q || ev.wi_lvl;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ten_q <= 1'b0;
        end else if (ev_start || busy_q) begin
            ten_q <= 1'b0;
        end else if (ev_fall) begin
            ten_q <= ack_end && ph_q == eeb_pkg::PH_WDATA && oe_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // page latches

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_q <= '0;
            for (int i = 0; i < eeb_pkg::PAGE_LEN; i++) begin
                page_buf_q[i] <= '0;
            end
        end else if (ev_start || prog_done) begin
            pend_q <= '0;
        end else if (byte_end && ph_q == eeb_pkg::PH_WDATA && !wi_seen_q) begin
            page_buf_q[page_idx] <= sr_q;
            pend_q[page_idx] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // self-timed program cycle

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
            prog_cnt_q <= '0;
        end else if (prog_go) begin
            busy_q <= 1'b1;
            prog_cnt_q <= '0;
        end else if (busy_q) begin
            if (prog_done) begin
                busy_q <= 1'b0;
            end else begin
                prog_cnt_q <= prog_cnt_q + 32'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < eeb_pkg::MEM_DEPTH; i++) begin
                mem_q[i] <= eeb_pkg::MEM_INIT;
            end
        end else if (prog_done) begin
            for (int i = 0; i < eeb_pkg::PAGE_LEN; i++) begin
                if (pend_q[i]) begin
                    mem_q[{addr_q[eeb_pkg::MEM_AW-1:eeb_pkg::PAGE_BITS], eeb_pkg::PAGE_BITS'(i)}]
                        <= page_buf_q[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    AST_START_SEL: assert property (ev_start |=> ph_q == eeb_pkg::PH_SEL && cnt_q == eeb_pkg::CNT_ZERO)
        else $error("start not taken");
    AST_IDLE_RELEASED: assert property (ph_q == eeb_pkg::PH_IDLE |-> !oe_q)
        else $error("sda driven in idle");
    AST_STOP_IDLE: assert property (ev_stop |=> ph_q == eeb_pkg::PH_IDLE && !oe_q)
        else $error("stop did not end transfer");
    AST_SEL_MISS: assert property (byte_end && ph_q == eeb_pkg::PH_SEL && !sel_ok
                                   |=> ph_q == eeb_pkg::PH_IDLE && !oe_q)
        else $error("mismatched select not released");
    AST_ADDR_ACK: assert property (byte_end && ph_q == eeb_pkg::PH_ADDR |=> oe_q)
        else $error("address byte not acked");
    AST_INHIBIT_NACK: assert property (byte_end && ph_q == eeb_pkg::PH_WDATA && wi_seen_q
                                       |=> !oe_q && $stable(pend_q))
        else $error("inhibited data byte acked");
    AST_PAGE_WRAP: assert property (byte_end && ph_q == eeb_pkg::PH_WDATA && !wi_seen_q
                                    |=> addr_q[eeb_pkg::PAGE_BITS-1:0] == $past(page_idx) + 1'b1
                                        && addr_q[eeb_pkg::MEM_AW-1:eeb_pkg::PAGE_BITS]
                                           == $past(addr_q[eeb_pkg::MEM_AW-1:eeb_pkg::PAGE_BITS]))
        else $error("page address did not wrap");
    AST_PROG_ONLY_STOP: assert property ($rose(busy_q) |-> $past(ev.stop) && $past(ten_q))
        else $error("program cycle without tenth slot stop");
    AST_BUSY_DEAF: assert property (busy_q |-> ph_q == eeb_pkg::PH_IDLE && !oe_q)
        else $error("bus served while busy");
    AST_READ_NACK: assert property (ack_end && ph_q == eeb_pkg::PH_RDATA && nack_q
                                    |=> ph_q == eeb_pkg::PH_IDLE && !oe_q)
        else $error("read continued after nack");
    AST_READ_INC: assert property (byte_end && ph_q == eeb_pkg::PH_RDATA |=> addr_q == $past(addr_q) + 1'b1)
        else $error("read address not advanced");

    COV_WRITE: cover property (prog_go);
    COV_READ_ACKED: cover property (ack_end && ph_q == eeb_pkg::PH_RDATA && !nack_q);
    COV_POLL_NACK: cover property (ev.start && busy_q);
    COV_INHIBIT: cover property (byte_end && ph_q == eeb_pkg::PH_WDATA && wi_seen_q);
endmodule // eeb_slave
`default_nettype wire

// *** testbench/eeb_mst_model.sv ***
// two-wire bus master model: start, stop, byte write and byte read on scl/sda
// assumes a pull-up on sda; pull high means the master pulls sda low
`timescale 1ns/1ps
`default_nettype none
module eeb_mst_model (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic pull
);
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    task automatic drv(input logic c, input logic p, input int n);
        scl <= c;
        pull <= p;
        repeat (n) @(posedge clk);
    endtask
    // data moves only while scl is low, sampled in the middle of scl high
    task automatic bit_x(input logic b, output logic r);
        drv(1'b0, pull, 4);
        drv(1'b0, !b, 4);
        drv(1'b1, !b, 4);
        r = sda_line;
        repeat (4) @(posedge clk);
    endtask
    task automatic start();
        drv(1'b0, pull, 4);
        drv(1'b0, 1'b0, 4);
        drv(1'b1, 1'b0, 8);
        drv(1'b1, 1'b1, 8);
    endtask
    task automatic stop();
        drv(1'b0, pull, 4);
        drv(1'b0, 1'b1, 4);
        drv(1'b1, 1'b1, 8);
        drv(1'b1, 1'b0, 8);
    endtask
    // msb first, sda released for the ninth slot; callers may let page writes wrap inside the page
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask
    // master acks every byte but the last, whose nack precedes the stop
    task automatic rbyte(input logic ack_m, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(!ack_m, r);
    endtask
endmodule // eeb_mst_model
`default_nettype wire

// *** testbench/eeb_slave_test.sv ***
// self-checking bench for the two-wire memory slave, driven through the master model
// assumes eeb_pkg compiled first; program time shortened through PROG_CYCLES
`timescale 1ns/1ps
`default_nettype none
module eeb_slave_test;
    localparam int unsigned PROG = 600;
    logic clk, sys_rst, scl, m_pull, sda_oe, sda_out, busy, write_inhibit, strap0, strap1, strap2;
    wire logic sda_line;
    int err_count = 0;
    int n_checks = 0;
    int bcnt = 0;
    int b0 = 0;
    logic [7:0] exp_mem [512];
    assign sda_line = !((sda_oe & !sda_out) | m_pull);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) if (busy === 1'b1) bcnt <= bcnt + 1;
    eeb_slave #(.PROG_CYCLES(PROG), .TYPE_ID(eeb_pkg::TYPE_ID_DFLT)) eeb_slave_inst (
        .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .write_inhibit(write_inhibit), .strap0(strap0), .strap1(strap1),
        .strap2(strap2), .busy(busy));
    eeb_mst_model eeb_mst_model_inst (.clk(clk), .sda_line(sda_line), .scl(scl), .pull(m_pull));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    function automatic logic [7:0] sel(input logic a8, input logic rd);
        return {eeb_pkg::TYPE_ID_DFLT, strap2, strap1, a8, rd};
    endfunction
    task automatic put(input logic [7:0] d, input logic exp_ack);
        logic a;
        eeb_mst_model_inst.wbyte(d, a);
        chk({15'h0, a}, {15'h0, exp_ack}, "ack");
    endtask
    task automatic pick(input logic [8:0] a);
        eeb_mst_model_inst.start();
        put(sel(a[8], 1'b0), 1'b1);
        put(a[7:0], 1'b1);
    endtask
    // page write; expected memory follows the low-nibble wrap
    task automatic wr(input logic [8:0] a, input int n, input logic [7:0] d0, input logic ok);
        pick(a);
        for (int i = 0; i < n; i++) begin
            put(d0 + 8'(i), ok);
            if (ok) exp_mem[{a[8:4], 4'(a[3:0] + i)}] = d0 + 8'(i);
        end
        b0 = bcnt;
        eeb_mst_model_inst.stop();
        chk({15'h0, busy}, {15'h0, ok}, "busy after stop");
    endtask
    task automatic rd(input logic [8:0] a, input int n);
        logic [7:0] d;
        pick(a);
        eeb_mst_model_inst.start();
        put(sel(a[8], 1'b1), 1'b1);
        for (int i = 0; i < n; i++) begin
            eeb_mst_model_inst.rbyte(i < n - 1, d);
            chk({8'h0, d}, {8'h0, exp_mem[9'(a + i)]}, "read data");
        end
        eeb_mst_model_inst.rbyte(1'b0, d);
        chk({8'h0, d}, 16'h00FF, "no drive after nack");
        eeb_mst_model_inst.stop();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (80000) @(posedge clk);
        err_count++;
        wrap_up();
    end
    initial begin
        logic r;
        sys_rst = 1'b1;
        write_inhibit = 1'b0;
        strap0 = 1'b0;
        strap1 = 1'b0;
        strap2 = 1'b1;
        for (int i = 0; i < 512; i++) exp_mem[i] = eeb_pkg::MEM_INIT;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clk);
        chk({14'h0, busy, sda_oe}, 16'h0000, "reset outputs");
        put(sel(1'b0, 1'b0), 1'b0);
        eeb_mst_model_inst.start();
        put({eeb_pkg::TYPE_ID_DFLT, !strap2, strap1, 2'b00}, 1'b0);
        eeb_mst_model_inst.start();
        put({~eeb_pkg::TYPE_ID_DFLT, strap2, strap1, 2'b00}, 1'b0);
        eeb_mst_model_inst.stop();
        wr(9'h11E, 3, 8'hA0, 1'b1);
        eeb_mst_model_inst.start();
        put(sel(1'b0, 1'b0), 1'b0);
        for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge clk);
        chk(16'(bcnt - b0), 16'(PROG), "busy length");
        eeb_mst_model_inst.start();
        put(sel(1'b0, 1'b0), 1'b1);
        eeb_mst_model_inst.stop();
        chk({15'h0, busy}, 16'h0000, "stop after select");
        rd(9'h11E, 3);
        rd(9'h110, 1);
        write_inhibit <= 1'b1;
        wr(9'h110, 1, 8'h55, 1'b0);
        rd(9'h110, 1);
        write_inhibit <= 1'b0;
        pick(9'h050);
        put(8'h77, 1'b1);
        eeb_mst_model_inst.bit_x(1'b1, r);
        eeb_mst_model_inst.stop();
        chk({15'h0, busy}, 16'h0000, "stop off slot");
        rd(9'h050, 1);
        wrap_up();
    end
endmodule // eeb_slave_test
`default_nettype wire
